// >>> rtl/gpfs_pkg.sv
// Operation
// - digital enable clear selects pin analog function
// - peripheral only when alternate and digital set
// - every pin selected independently of others
// - other pins reset to tri-stated zeroes, digital enable clear
// - reset restores every selection and pull setting
// - serial, sync serial, two-wire pins reset code 1
// - debug pins reset pulled up, code 3
// - port A carries serial and sync serial
// - port B capture, two-wire, comparator, test reset
// - port C debug pins and capture/compare
// - twenty-eight pins over five ports
// - alternate and digital enable set, with the pin's own function code, give peripheral pin control
package gpfs_pkg;
  // pin count and field widths
  localparam int NUM_PINS = 28;
  localparam int PIN_IDX_W = 5;
  localparam int CODE_W = 4;
  localparam int RD_W = 8;
  // flattened pin index of each port's bit 0
  localparam int PORT_A_BASE = 0;
  localparam int PORT_B_BASE = 6;
  localparam int PORT_C_BASE = 14;
  localparam int PORT_D_BASE = 22;
  localparam int PORT_E_BASE = 26;
  // function codes
  localparam logic [3:0] CODE_NONE = 4'h0;
  localparam logic [3:0] CODE_PERIPH = 4'h1;
  localparam logic [3:0] CODE_DEBUG = 4'h3;
  // reset vectors, bit n is flattened pin n
  localparam logic [27:0] RST_AFSEL = 28'h003C33F;
  localparam logic [27:0] RST_DEN = 28'h003C33F;
  localparam logic [27:0] RST_PUR = 28'h003C000;
  localparam logic [27:0] RST_PDR = 28'h0000000;
  // pins owning a digital peripheral signal
  localparam logic [27:0] HAS_FUNC = 28'h33BEBFF;
  // pins of the debug group, test reset pin stays on code 1
  localparam logic [27:0] DEBUG_PINS = 28'h003C000;

  // function code that reaches a pin's peripheral signal
  function automatic logic [3:0] funcCode(input int idx);
    if (DEBUG_PINS[idx]) begin
      funcCode = CODE_DEBUG;
    end else if (HAS_FUNC[idx]) begin
      funcCode = CODE_PERIPH;
    end else begin
      funcCode = CODE_NONE;
    end
  endfunction : funcCode

  // reset code of a pin
  function automatic logic [3:0] rstCode(input int idx);
    if (RST_PUR[idx]) begin
      rstCode = CODE_DEBUG;
    end else if (RST_AFSEL[idx]) begin
      rstCode = CODE_PERIPH;
    end else begin
      rstCode = CODE_NONE;
    end
  endfunction : rstCode
endpackage : gpfs_pkg

// >>> rtl/gpfs_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
// per-pin selection state shared by the holder and the router
interface gpfs_cfg_if;
  logic [27:0] afsel; // alternate select per pin
  logic [27:0] digital_enable_bit; // digital enable per pin
  logic [27:0][3:0] code; // function code per pin
  modport owner (output afsel, output digital_enable_bit, output code);
  modport user (input afsel, input digital_enable_bit, input code);
endinterface : gpfs_cfg_if
`default_nettype wire

// >>> rtl/gpfs_pin_route.sv
`timescale 1ns/1ps
`default_nettype none
// combinational routing of all pins
module gpfs_pin_route (
  gpfs_cfg_if.user cfg,
  input wire logic [27:0] padIn,
  input wire logic [27:0] gpioOut,
  input wire logic [27:0] gpioOe,
  input wire logic [27:0] periphOut,
  input wire logic [27:0] periphOe,
  output logic [27:0] padOutNxt,
  output logic [27:0] padOeNxt,
  output logic [27:0] gpioInNxt,
  output logic [27:0] periphInNxt,
  output logic [27:0] periphSelNxt
);
  // each pin only looks at its own settings
  always_comb begin
    for (int i = 0; i < gpfs_pkg::NUM_PINS; i++) begin
      // peripheral link needs both bits and the pin's own code
      periphSelNxt[i] = cfg.afsel[i] & cfg.digital_enable_bit[i] & gpfs_pkg::HAS_FUNC[i]
        & (cfg.code[i] == gpfs_pkg::funcCode(i));
      if (!cfg.digital_enable_bit[i]) begin
        // analog use: driver and input path off
        padOutNxt[i] = 1'b0;
        padOeNxt[i] = 1'b0;
      end else if (cfg.afsel[i]) begin
        // peripheral owns the pin, silent on code mismatch
        padOutNxt[i] = periphSelNxt[i] & periphOut[i];
        padOeNxt[i] = periphSelNxt[i] & periphOe[i];
      end else begin
        // data and direction logic owns the pin
        padOutNxt[i] = gpioOut[i];
        padOeNxt[i] = gpioOe[i];
      end
      gpioInNxt[i] = cfg.digital_enable_bit[i] & ~cfg.afsel[i] & padIn[i];
      periphInNxt[i] = periphSelNxt[i] & padIn[i];
    end
  end
endmodule : gpfs_pin_route
`default_nettype wire

// >>> rtl/gpfs_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none
// pin function selection for five ports, 28 pins
module gpfs_pin_mux (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cfgWe,
  input wire logic [4:0] cfgPin,
  input wire logic cfgAfsel,
  input wire logic cfgDen,
  input wire logic cfgPur,
  input wire logic cfgPdr,
  input wire logic [3:0] cfgCode,
  output logic [7:0] cfgRdData,
  input wire logic [27:0] padIn,
  output logic [27:0] padOut,
  output logic [27:0] padOe,
  output logic [27:0] padPullUp,
  output logic [27:0] padPullDown,
  output logic [27:0] analogSel,
  input wire logic [27:0] gpioOut,
  input wire logic [27:0] gpioOe,
  output logic [27:0] gpioIn,
  input wire logic [27:0] periphOut,
  input wire logic [27:0] periphOe,
  output logic [27:0] periphIn,
  output logic [27:0] periphSel
);
  gpfs_cfg_if cfg(); // selection state to the router
  logic [27:0] afsel_r; // alternate select bits
  logic [27:0] den_r; // digital enable bits
  logic [27:0] pur_r; // pull-up bits
  logic [27:0] pdr_r; // pull-down bits
  logic [27:0][3:0] code_r; // function codes
  // routing results, registered below
  logic [27:0] padOut_nxt;
  logic [27:0] padOe_nxt;
  logic [27:0] gpioIn_nxt;
  logic [27:0] periphIn_nxt;
  logic [27:0] periphSel_nxt;
  logic wrHit; // write aimed at an existing pin

  // writes past the last pin are dropped without trace
  assign wrHit = cfgWe && (cfgPin < 5'(gpfs_pkg::NUM_PINS));
  assign cfg.afsel = afsel_r;
  assign cfg.digital_enable_bit = den_r;
  assign cfg.code = code_r;

  // selection and pull bits, only the addressed pin changes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      // power-on or external reset restores defaults
      afsel_r <= gpfs_pkg::RST_AFSEL;
      den_r <= gpfs_pkg::RST_DEN;
      pur_r <= gpfs_pkg::RST_PUR;
      pdr_r <= gpfs_pkg::RST_PDR;
      for (int i = 0; i < gpfs_pkg::NUM_PINS; i++) begin
        code_r[i] <= gpfs_pkg::rstCode(i);
      end
    end else if (wrHit) begin
      // single pin update
      afsel_r[cfgPin] <= cfgAfsel;
      den_r[cfgPin] <= cfgDen;
      pur_r[cfgPin] <= cfgPur;
      pdr_r[cfgPin] <= cfgPdr;
      code_r[cfgPin] <= cfgCode;
    end
  end

  // readback of the addressed pin, zero past the last pin
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfgRdData <= 8'h00;
    end else if (cfgPin < 5'(gpfs_pkg::NUM_PINS)) begin
      cfgRdData <= {pdr_r[cfgPin], pur_r[cfgPin], den_r[cfgPin], afsel_r[cfgPin],
        code_r[cfgPin]};
    end else begin
      cfgRdData <= 8'h00;
    end
  end

  // routing of every pin
  gpfs_pin_route u_route (
    .cfg(cfg),
    .padIn(padIn),
    .gpioOut(gpioOut),
    .gpioOe(gpioOe),
    .periphOut(periphOut),
    .periphOe(periphOe),
    .padOutNxt(padOut_nxt),
    .padOeNxt(padOe_nxt),
    .gpioInNxt(gpioIn_nxt),
    .periphInNxt(periphIn_nxt),
    .periphSelNxt(periphSel_nxt)
  );

  // registered pad side
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      padOut <= 28'h0000000;
      padOe <= 28'h0000000;
      padPullUp <= 28'h0000000;
      padPullDown <= 28'h0000000;
      analogSel <= 28'h0000000;
    end else begin
      padOut <= padOut_nxt;
      padOe <= padOe_nxt;
      padPullUp <= pur_r;
      padPullDown <= pdr_r;
      analogSel <= ~den_r;
    end
  end

  // registered internal side
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gpioIn <= 28'h0000000;
      periphIn <= 28'h0000000;
      periphSel <= 28'h0000000;
    end else begin
      gpioIn <= gpioIn_nxt;
      periphIn <= periphIn_nxt;
      periphSel <= periphSel_nxt;
    end
  end

  // all checks run on the system clock and rest during reset
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // a write to one pin and its effect one cycle later
  sequence s_pinWrite;
    wrHit;
  endsequence
  // only the addressed pin may change its alternate select
  sequence s_onlyThatPin;
    ((afsel_r ^ $past(afsel_r)) & ~(28'h0000001 << $past(cfgPin))) == 28'h0000000;
  endsequence
  // every field of the addressed pin holds what was written
  sequence s_fieldsLand;
    afsel_r[$past(cfgPin)] == $past(cfgAfsel) && den_r[$past(cfgPin)] == $past(cfgDen)
      && pur_r[$past(cfgPin)] == $past(cfgPur) && pdr_r[$past(cfgPin)] == $past(cfgPdr)
      && code_r[$past(cfgPin)] == $past(cfgCode);
  endsequence
  // a write aimed past the last pin, and nothing moving after it
  sequence s_refusedWrite;
    cfgWe && (cfgPin >= 5'(gpfs_pkg::NUM_PINS));
  endsequence
  sequence s_noneMoved;
    $stable(afsel_r) && $stable(den_r) && $stable(pur_r) && $stable(pdr_r)
      && $stable(code_r);
  endsequence

  // analog select is the registered inverse of digital enable
  a_analog_follows_den: assert property (!$past(rst) |-> analogSel == ~$past(den_r))
    else $error("analog select not the inverse of digital enable");

  // a peripheral link needs both select bits of the cycle before
  a_periph_needs_both: assert property (
    (periphSel & ~($past(afsel_r) & $past(den_r))) == 28'h0000000)
    else $error("peripheral linked without both select bits");

  // a write changes the alternate select of the addressed pin only, and all of its fields land
  a_write_one_pin: assert property (s_pinWrite |=> s_onlyThatPin)
    else $error("write changed a pin other than the addressed one");
  a_write_lands: assert property (s_pinWrite |=> s_fieldsLand)
    else $error("write did not land in the addressed pin");

  // a pin index past the last pin is ignored and reads as zero
  a_refused_pin: assert property (s_refusedWrite |=> s_noneMoved)
    else $error("write past the last pin changed a setting");
  a_rdback_off: assert property (
    (cfgPin >= 5'(gpfs_pkg::NUM_PINS)) |=> cfgRdData == 8'h00)
    else $error("readback past the last pin not zero");

  // defaults straight after reset release
  a_release_defaults: assert property (
    $fell(rst) |-> afsel_r == gpfs_pkg::RST_AFSEL && den_r == gpfs_pkg::RST_DEN
    && pdr_r == gpfs_pkg::RST_PDR)
    else $error("selection bits not at default after reset");
  a_serial_code_rst: assert property (
    $fell(rst) |-> code_r[0] == gpfs_pkg::CODE_PERIPH
    && code_r[9] == gpfs_pkg::CODE_PERIPH && code_r[18] == gpfs_pkg::CODE_NONE)
    else $error("serial pin reset code wrong");
  a_debug_code_rst: assert property (
    $fell(rst) |-> code_r[14] == gpfs_pkg::CODE_DEBUG
    && code_r[17] == gpfs_pkg::CODE_DEBUG && pur_r == gpfs_pkg::RST_PUR)
    else $error("debug pin reset state wrong");
  a_rst_links: assert property ($fell(rst) |=> periphSel == gpfs_pkg::RST_AFSEL)
    else $error("default pins not linked after reset");
  // pull outputs follow the pull bits one cycle late
  a_pull_follows: assert property (
    !$past(rst) |-> padPullUp == $past(pur_r) && padPullDown == $past(pdr_r))
    else $error("pad pulls not following the pull bits");

  // direction logic owns the driver in plain mode
  a_gpio_owns_pin: assert property (
    ((padOe ^ $past(gpioOe)) & $past(den_r) & ~$past(afsel_r)) == 28'h0000000)
    else $error("pad enable not from direction logic in plain mode");
  // the linked peripheral owns the driver in alternate mode
  a_periph_owns_pin: assert property (
    ((padOe ^ (periphSel & $past(periphOe))) & $past(den_r) & $past(afsel_r)) == 28'h0000000)
    else $error("pad enable not from the linked peripheral");
  // plain-mode input path carries the pad level
  a_gpio_in_path: assert property (
    gpioIn == ($past(den_r) & ~$past(afsel_r) & $past(padIn)))
    else $error("plain input path not carrying the pad level");

  // digital enable clear leaves driver and inputs quiet
  a_den_off_quiet: assert property (
    ((padOe | gpioIn | periphIn) & ~$past(den_r)) == 28'h0000000)
    else $error("digital path active with digital enable clear");
  a_den_no_drive: assert property (
    (padOut & ~$past(den_r)) == 28'h0000000)
    else $error("pad output level set with digital enable clear");

  // pins without a peripheral signal never link
  a_no_func_pins: assert property (
    (periphSel & ~gpfs_pkg::HAS_FUNC) == 28'h0000000)
    else $error("peripheral linked on a pin without a function");
endmodule : gpfs_pin_mux
`default_nettype wire

// >>> verification/gpfs_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// pads and on-chip peripherals on the far side of the mux
module gpfs_far_model (
  input wire logic sys_clk,
  input wire logic [27:0] padOut,
  input wire logic [27:0] padOe,
  input wire logic [27:0] padPullUp,
  input wire logic [27:0] padPullDown,
  output logic [27:0] padIn,
  output logic [27:0] periphOut,
  output logic [27:0] periphOe
);
  logic [27:0] floatLvl_r = 28'h0; // level of a pad nobody holds
  // a floating pad wanders every cycle, so a stale value never passes
  always @(posedge sys_clk) begin
    floatLvl_r <= ~floatLvl_r;
  end
  // wire level: driver first, then pull-up, then pull-down, else wander
  assign padIn = (padOe & padOut) | (~padOe & (padPullUp | (~padPullDown & floatLvl_r)));
  // peripherals drive a fixed pattern; the second serial receive pin is never driven
  assign periphOut = 28'h5A5A5A5;
  assign periphOe = 28'hEFFFFFF;
endmodule : gpfs_far_model
`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the pin mux
module tb;
  localparam logic [31:0] DEF = 32'h003C33F; // pins leaving reset on a peripheral
  localparam logic [27:0] HASF = 28'h33BEBFF; // pins owning a peripheral signal
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic cfgWe = 1'b0;
  logic [4:0] cfgPin = 5'h00;
  logic cfgAfsel = 1'b0, cfgDen = 1'b0, cfgPur = 1'b0, cfgPdr = 1'b0;
  logic [3:0] cfgCode = 4'h0;
  logic [27:0] gpioOut = 28'h0, gpioOe = 28'h0;
  logic [7:0] cfgRdData;
  logic [27:0] padIn, padOut, padOe, padPullUp, padPullDown, analogSel, gpioIn;
  logic [27:0] periphOut, periphOe, periphIn, periphSel;
  int n_errors = 0, compares = 0, cycles = 0;
  gpfs_pin_mux uut (.sys_clk, .rst, .cfgWe, .cfgPin, .cfgAfsel, .cfgDen, .cfgPur, .cfgPdr,
    .cfgCode, .cfgRdData, .padIn, .padOut, .padOe, .padPullUp, .padPullDown, .analogSel,
    .gpioOut, .gpioOe, .gpioIn, .periphOut, .periphOe, .periphIn, .periphSel);
  gpfs_far_model far (.sys_clk, .padOut, .padOe, .padPullUp, .padPullDown, .padIn,
    .periphOut, .periphOe);
  // 200 MHz clock
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      complete_run();
    end
  end
  // compare and count
  task automatic check(input string what, input logic [27:0] seen, input logic [27:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one config write, all fields at once
  task automatic wr(input int p, input logic a, d, u, w, input logic [3:0] c);
    @(negedge sys_clk);
    cfgWe = 1'b1;
    cfgPin = p[4:0];
    {cfgAfsel, cfgDen, cfgPur, cfgPdr, cfgCode} = {a, d, u, w, c};
    @(negedge sys_clk);
    cfgWe = 1'b0;
  endtask : wr
  // let register and routing stages land
  task automatic settle;
    repeat (2) @(negedge sys_clk);
  endtask : settle
  // readback, one cycle late
  task automatic rd(input int p, input logic [7:0] exp);
    @(negedge sys_clk);
    cfgPin = p[4:0];
    @(negedge sys_clk);
    check("cfgRdData", {20'h0, cfgRdData}, {20'h0, exp});
  endtask : rd
  // reset readback of a pin
  function automatic logic [7:0] rstVal(input int i);
    if (i >= 14 && i <= 17) return 8'h73;
    return DEF[i] ? 8'h31 : 8'h00;
  endfunction : rstVal
  // defaults straight after reset
  task automatic s_reset;
    settle();
    check("analogSel", analogSel, ~DEF[27:0]);
    check("padOe", padOe, DEF[27:0]);
    check("padPullUp", padPullUp, 28'h003C000);
    check("padPullDown", padPullDown, 28'h0);
    for (int i = 0; i < 32; i++) rd(i, rstVal(i));
  endtask : s_reset
  // every pin as plain digital pin
  task automatic s_gpio;
    gpioOut = 28'hC3C3C3C;
    gpioOe = 28'hFFF0FFF;
    for (int i = 0; i < 28; i++) wr(i, 1'b0, 1'b1, i == 26, i == 27, 4'hF);
    settle();
    check("padOe", padOe, gpioOe);
    check("padOut", padOut & gpioOe, gpioOut & gpioOe);
    check("gpioIn", gpioIn & gpioOe, gpioOut & gpioOe);
    check("periphSel", periphSel, 28'h0);
    check("analogSel", analogSel, 28'h0);
    check("padPullUp", padPullUp, 28'h4000000);
    check("padPullDown", padPullDown, 28'h8000000);
  endtask : s_gpio
  // every pin on its peripheral, then a wrong code and an analog pin
  task automatic s_periph;
    for (int i = 0; i < 28; i++) wr(i, 1'b1, 1'b1, 1'b0, 1'b0, (i >= 14 && i <= 17) ? 4'h3 : 4'h1);
    settle();
    check("periphSel", periphSel, HASF);
    check("padOe", padOe, HASF & periphOe);
    check("padOut", padOut & HASF, periphOut & HASF);
    check("periphIn", periphIn & periphOe, periphOut & HASF & periphOe);
    check("gpioIn", gpioIn, 28'h0);
    wr(6, 1'b1, 1'b1, 1'b0, 1'b0, 4'h2);
    wr(0, 1'b1, 1'b0, 1'b0, 1'b0, 4'h1);
    settle();
    check("periphSel", periphSel, HASF & ~28'h0000041);
    check("padOe", padOe, HASF & ~28'h0000041 & periphOe);
    check("analogSel", analogSel, 28'h0000001);
    rd(0, 8'h11);
    rd(6, 8'h32);
    // a write past the last pin must leave every pin alone
    wr(30, 1'b1, 1'b0, 1'b1, 1'b1, 4'hF);
    settle();
    check("padPullUp", padPullUp, 28'h0);
    check("padPullDown", padPullDown, 28'h0);
    check("analogSel", analogSel, 28'h0000001);
    rd(30, 8'h00);
  endtask : s_periph
  // reset in mid-run
  task automatic s_rerst;
    @(negedge sys_clk);
    rst = 1'b1;
    @(negedge sys_clk);
    check("analogSel", analogSel, 28'h0);
    rst = 1'b0;
    settle();
    check("analogSel", analogSel, ~DEF[27:0]);
    check("padPullUp", padPullUp, 28'h003C000);
    rd(0, 8'h31);
    rd(27, 8'h00);
  endtask : s_rerst
  // verdict and end of run
  task automatic complete_run;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  // main sequence
  initial begin
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    s_reset();
    s_gpio();
    s_periph();
    s_rerst();
    complete_run();
  end
endmodule : tb
`default_nettype wire
